/* testbench/tb_deep_standby_wake_retention.sv */
// Self-checking bench for the deep standby wake and retention block.
`timescale 1ns/1ns
module tb_deep_standby_wake_retention;
  import dsw_pkg::*;
  logic        clock, arst_n, wr, rd, standby_enter, entry_reset;
  logic        lvd_reset, wake_req, irq, wake_pin_zero, rtc_irq, lvd_irq;
  logic        pin0_low, rtc_on, lvd_on;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bank_keep;
  logic [4:0]  wake_pins, analog_input_enable, pins_low;
  logic [3:0]  hold;
  int          fail_count, checked, cycles;

  deep_standby_wake_retention #(.DUAL_BANK(1'b1)) uut (
    .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .standby_enter(standby_enter),
    .entry_reset(entry_reset), .lvd_reset(lvd_reset),
    .voltage_hold_setting(hold), .wake_req(wake_req),
    .bank_keep(bank_keep), .wake_pin_zero(wake_pin_zero),
    .wake_pins(wake_pins), .analog_input_enable(analog_input_enable),
    .rtc_irq(rtc_irq), .lvd_irq(lvd_irq), .irq(irq));

  wake_sources far (
    .pin0_low(pin0_low), .pins_low(pins_low), .rtc_on(rtc_on),
    .lvd_on(lvd_on), .wake_pin_zero(wake_pin_zero), .wake_pins(wake_pins),
    .rtc_irq(rtc_irq), .lvd_irq(lvd_irq));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic chk(input logic [5:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask : chk

  // Enter standby; if nothing wakes it in time, pin zero is pulled low.
  task automatic stby(input logic [7:0] cause);
    int n;
    @(posedge clock) standby_enter <= 1'b1;
    @(posedge clock) standby_enter <= 1'b0;
    n = 0;
    while (wake_req !== 1'b1 && n < 14) begin
      @(posedge clock);
      if (n == 6) pin0_low <= 1'b1;
      #1;
      n++;
    end
    check(wake_req, 1'b1);
    @(posedge clock) pin0_low <= 1'b0;
    #1;
    check(wake_req, 1'b0);
    chk(IDX_CAUSE, {24'h0, cause});
    chk(IDX_CAUSE, 32'h0);
  endtask : stby

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_fields;
    chk(IDX_WAKE_EN, 32'h0);
    chk(IDX_LEVEL, 32'h0);
    chk(IDX_RETAIN, 32'h0);
    bus_wr(IDX_LEVEL, 32'hFF);
    chk(IDX_LEVEL, 32'h1F);
    bus_wr(IDX_RETAIN, 32'hFF);
    chk(IDX_RETAIN, 32'h03);
    bus_wr(6'h07, 32'hFF);
    chk(6'h07, 32'h0);
    for (int c = 0; c < 4; c++) begin
      bus_wr(IDX_RETAIN, c);
      @(posedge clock);
      #1;
      check(bank_keep, {c[0], c[1]});
    end
    $display("test fields done");
  endtask : t_fields

  task automatic t_backup;
    for (int i = 0; i < 4; i++) chk(IDX_BACKUP0 + i, 32'h0);
    for (int i = 0; i < 4; i++) bus_wr(IDX_BACKUP0 + i, 32'hA5C3_0F01 << i);
    bus_wr(IDX_WAKE_EN, 32'hFF);
    bus_wr(IDX_LEVEL, 32'h15);
    @(posedge clock) entry_reset <= 1'b1;
    @(posedge clock) entry_reset <= 1'b0;
    for (int i = 0; i < 4; i++) chk(IDX_BACKUP0 + i, 32'hA5C3_0F01 << i);
    chk(IDX_WAKE_EN, 32'hFB);
    chk(IDX_LEVEL, 32'h15);
    chk(IDX_RETAIN, 32'h3);
    @(posedge clock) hold <= HOLD_CLEAR_VAL;
    @(posedge clock) lvd_reset <= 1'b1;
    @(posedge clock) lvd_reset <= 1'b0;
    chk(IDX_BACKUP3, 32'h0);
    chk(IDX_RETAIN, 32'h0);
    $display("test backup done");
  endtask : t_backup

  task automatic t_wake;
    bus_wr(IDX_IRQ_MASK, 32'h1);
    stby(8'h04);
    check(irq, 1'b1);
    chk(IDX_IRQ_STAT, 32'h3);
    chk(IDX_IRQ_MASK, 32'h1);
    bus_wr(IDX_IRQ_STAT, 32'h3);
    @(posedge clock);
    #1;
    check(irq, 1'b0);
    bus_wr(IDX_WAKE_EN, 32'h08);
    bus_wr(IDX_LEVEL, 32'h01);
    stby(8'h08);
    analog_input_enable <= 5'h01;
    stby(8'h04);
    analog_input_enable <= 5'h00;
    bus_wr(IDX_WAKE_EN, 32'h0);
    rtc_on <= 1'b1;
    stby(8'h04);
    bus_wr(IDX_WAKE_EN, 32'h1);
    stby(8'h01);
    rtc_on <= 1'b0;
    bus_wr(IDX_WAKE_EN, 32'h2);
    lvd_on <= 1'b1;
    stby(8'h02);
    lvd_on <= 1'b0;
    $display("test wake done");
  endtask : t_wake

  // Power-on reset in mid-run, taken while in standby, clears all.
  task automatic t_reset;
    bus_wr(IDX_RETAIN, 32'h3);
    bus_wr(IDX_BACKUP0, 32'h1234_5678);
    @(posedge clock) standby_enter <= 1'b1;
    @(posedge clock) standby_enter <= 1'b0;
    chk(IDX_CTRL, 32'h1);
    @(posedge clock) arst_n <= 1'b0;
    @(posedge clock) arst_n <= 1'b1;
    chk(IDX_CTRL, 32'h0);
    chk(IDX_RETAIN, 32'h0);
    chk(IDX_BACKUP0, 32'h0);
    check(bank_keep, 32'h0);
    check(wake_req, 1'b0);
    $display("test reset done");
  endtask : t_reset

  initial begin
    {arst_n, wr, rd, standby_enter, entry_reset, lvd_reset} = '0;
    {pin0_low, rtc_on, lvd_on, pins_low, analog_input_enable} = '0;
    {addr, wdata, hold, fail_count, checked, cycles} = '0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    t_fields();
    t_backup();
    t_wake();
    t_reset();
    give_verdict();
  end
endmodule : tb_deep_standby_wake_retention

/* testbench/wake_sources.sv */
// Model of the external wake pins and wake interrupt sources.
`timescale 1ns/1ns
module wake_sources (
  // Bench commands
  input  wire logic       pin0_low,
  input  wire logic [4:0] pins_low,
  input  wire logic       rtc_on,
  input  wire logic       lvd_on,
  // Far-side levels
  output logic            wake_pin_zero,
  output logic      [4:0] wake_pins,
  output logic            rtc_irq,
  output logic            lvd_irq
);
  // Released pins rest at the pull-up level, never at a stale value.
  assign wake_pin_zero = ~pin0_low;
  assign wake_pins     = ~pins_low;
  assign rtc_irq       = rtc_on;
  assign lvd_irq       = lvd_on;
endmodule : wake_sources

/* verilog/deep_standby_wake_retention.sv */
// Deep standby wake sources, SRAM retention select and backup bytes.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

// Function
// RQ1: Bit rtc_wake_enable enables RTC interrupt wake, default off.
// RQ2: Bit lvd_wake_enable set lets an LOW_VOLTAGE_DETECTOR interrupt wake the device.
// RQ3: Wake pin zero is always a wake source with no enable.
// RQ4: Wake enables and level selects survive the standby entry reset.
// RQ5: Five level bits 4:0 pick low (0) or high (1) wake for pins 5..1.
// RQ6: Wake pin zero wakes on a low level, fixed.
// RQ7: Wake is level sensitive; an active pin wakes at once on entry.
// RQ8: Level bits 7:5 and retention bits 7:2 read zero, writes ignored.
// RQ9: Retention code 00 discards SRAM and 11 keeps it.
// RQ10: Dual bank: code 01 keeps bank 1 only, 10 keeps bank 0 only.
// RQ11: Retention resets only on power-on or LOW_VOLTAGE_DETECTOR reset.
// RQ12: Sixteen byte backup registers, four per word, reset 0x00, kept.
// RQ13: Backup bytes clear on power-on, or LOW_VOLTAGE_DETECTOR reset if hold is 0001.
// RQ14: A pin shared with analog input is blocked while its enable is 1.
// RQ15: Pins 1..5 have individual wake enables, default off.
// RQ16: Wake cause flags set only in standby and clear on read.
// RQ17: The wake request is the OR of pin zero low and enabled sources.
module deep_standby_wake_retention
  import dsw_pkg::*;
#(
  parameter bit DUAL_BANK  = 1'b0,
  parameter bit HOLD_GATED = 1'b0
) (
  // Clock and power-on reset
  input  wire  logic        clock,
  input  wire  logic        arst_n,
  // Register port
  input  wire  logic [5:0]  addr,
  input  wire  logic [31:0] wdata,
  input  wire  logic        wr,
  input  wire  logic        rd,
  output logic       [31:0] rdata,
  // Power controller
  input  wire  logic        standby_enter,
  input  wire  logic        entry_reset,
  input  wire  logic        lvd_reset,
  input  wire  logic [3:0]  voltage_hold_setting,
  output logic              wake_req,
  output logic       [1:0]  bank_keep,
  // Wake sources
  input  wire  logic        wake_pin_zero,
  input  wire  logic [4:0]  wake_pins,
  input  wire  logic [4:0]  analog_input_enable,
  input  wire  logic        rtc_irq,
  input  wire  logic        lvd_irq,
  // Interrupt
  output logic              irq
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  localparam logic [7:0] SYNC_IDLE = 8'h3F;
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // Pins rest high and the interrupt lines rest low, so the
      // synchronisers start at the idle levels and see no false source.
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta_q <= {lvd_irq, rtc_irq, wake_pin_zero, wake_pins};
      sync_q <= meta_q;
    end
  end

  logic       pin0_s;
  logic       rtc_s;
  logic       lvd_s;
  logic [4:0] pins_s;
  assign pins_s = sync_q[4:0];
  assign pin0_s = sync_q[5];
  assign rtc_s  = sync_q[6];
  assign lvd_s  = sync_q[7];

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  state_s s_q;
  state_s s_d;
  bus_req_s req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic [4:0] pin_hit;
  logic [7:0] cause_now;
  logic       any_wake;
  logic       backup_clr;

  // Bit two of the wake enable word has no source behind it.
  localparam logic [7:0] WAKE_EN_MASK = 8'hFB;

  // True for the four word indices of the backup store.
  function automatic logic is_backup(input logic [5:0] idx);
    return idx >= IDX_BACKUP0 && idx <= IDX_BACKUP3;
  endfunction : is_backup

  always_comb begin
    s_d = s_q;
    // Analog use blocks the pin even with its wake enable set.
    pin_hit = s_q.wake_en[PINS_MSB:PINS_LSB] & ~analog_input_enable // RQ14
              & ~(pins_s ^ s_q.level); // RQ5 RQ15
    cause_now = {pin_hit, ~pin0_s, // RQ6
                 lvd_s & s_q.wake_en[LVD_BIT], // RQ2
                 rtc_s & s_q.wake_en[RTC_BIT]}; // RQ1
    any_wake = |cause_now; // RQ17 RQ3
    // A low-voltage reset may be told to spare the backup store.
    backup_clr = lvd_reset &&
                 (!HOLD_GATED || voltage_hold_setting == HOLD_CLEAR_VAL);

    // Reads; the cause register clears once read, a new cause wins.
    s_d.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        IDX_WAKE_EN:  s_d.rdata = {24'h0, s_q.wake_en & WAKE_EN_MASK};
        IDX_LEVEL:    s_d.rdata = {27'h0, s_q.level}; // RQ8
        IDX_RETAIN:   s_d.rdata = {30'h0, s_q.retain}; // RQ8
        IDX_CAUSE: begin
          s_d.rdata = {24'h0, s_q.cause};
          s_d.cause = '0; // RQ16
        end
        IDX_CTRL:     s_d.rdata = {30'h0, s_q.mode};
        IDX_IRQ_STAT: s_d.rdata = {30'h0, s_q.irq_stat};
        IDX_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
        default: begin
          if (is_backup(req.addr))
            s_d.rdata = s_q.backup[req.addr[1:0]*32 +: 32]; // RQ12
        end
      endcase
    end

    if (req.wr) begin
      unique case (req.addr)
        IDX_WAKE_EN:  s_d.wake_en = req.wdata[7:0] & WAKE_EN_MASK;
        IDX_LEVEL:    s_d.level   = req.wdata[4:0]; // RQ8 RQ5
        IDX_RETAIN:   s_d.retain  = req.wdata[1:0]; // RQ9
        IDX_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~req.wdata[1:0];
        IDX_IRQ_MASK: s_d.irq_mask = req.wdata[1:0];
        default: begin
          if (is_backup(req.addr))
            s_d.backup = put_word(s_q.backup, req.addr[1:0],
                                  req.wdata); // RQ12
        end
      endcase
    end

    // Mode sequencing; wake is level sensitive, so entry with an
    // active source returns in the next cycle.
    unique case (s_q.mode)
      ST_RUN: begin
        if (standby_enter) s_d.mode = ST_STANDBY;
      end
      ST_STANDBY: begin
        s_d.cause = s_d.cause | cause_now; // RQ16
        if (any_wake) begin // RQ7
          s_d.mode = ST_WAKE;
          s_d.irq_stat[0] = 1'b1;
        end
      end
      ST_WAKE: s_d.mode = ST_RUN;
      default: s_d.mode = ST_RUN;
    endcase
    // Both status bits are set after the clear above, so a set wins.
    if (s_q.mode == ST_RUN && standby_enter) s_d.irq_stat[1] = 1'b1;

    s_d.wake = (s_q.mode == ST_STANDBY) && any_wake; // RQ17
    unique case (s_q.retain)
      RET_NONE:  s_d.bank_keep = 2'b00; // RQ9
      RET_BANK1: s_d.bank_keep = DUAL_BANK ? 2'b10 : 2'b00; // RQ10
      RET_BANK0: s_d.bank_keep = DUAL_BANK ? 2'b01 : 2'b00; // RQ10
      RET_BOTH:  s_d.bank_keep = 2'b11; // RQ9
    endcase

    // Entry reset touches neither enables, levels, retention nor backup.
    if (entry_reset) begin // RQ4
      s_d.irq_mask = '0;
    end
    if (lvd_reset) begin
      s_d.wake_en = '0;
      s_d.level   = '0;
      s_d.retain  = RET_NONE; // RQ11
      s_d.cause   = '0;
      s_d.mode    = ST_RUN;
    end
    if (backup_clr) s_d.backup = '0; // RQ13

    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) s_q <= '0; // RQ11 RQ13
    else         s_q <= s_d;
  end

  assign rdata     = s_q.rdata;
  assign wake_req  = s_q.wake;
  assign bank_keep = s_q.bank_keep;
  assign irq       = s_q.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence in_standby_pin0_low;
    s_q.mode == ST_STANDBY && !pin0_s;
  endsequence

  pin_zero_wake_a: assert property ( // RQ3
    in_standby_pin0_low |=> wake_req)
    else $error("pin zero low did not wake");
  rtc_gate_a: assert property ( // RQ1
    s_q.mode == ST_STANDBY && !any_wake |=> !wake_req)
    else $error("wake without source");
  rtc_wake_a: assert property ( // RQ1
    s_q.mode == ST_STANDBY && rtc_s && s_q.wake_en[RTC_BIT]
      |=> wake_req && s_q.cause[RTC_BIT])
    else $error("rtc wake missed");
  lvd_wake_a: assert property ( // RQ2
    s_q.mode == ST_STANDBY && lvd_s && s_q.wake_en[LVD_BIT]
      |=> wake_req)
    else $error("lvd wake missed");
  analog_block_a: assert property ( // RQ14
    (pin_hit & analog_input_enable) == 5'h0)
    else $error("analog pin not blocked");
  retain_code_a: assert property ( // RQ9
    $past(s_q.retain) == RET_BOTH |-> bank_keep == 2'b11)
    else $error("retain both not applied");
  level_read_a: assert property ( // RQ8
    rd && addr == IDX_LEVEL |=> rdata[31:5] == 27'h0)
    else $error("level upper bits not zero");
  cause_clear_a: assert property ( // RQ16
    rd && addr == IDX_CAUSE && s_q.mode != ST_STANDBY |=> s_q.cause == 8'h0)
    else $error("cause not cleared on read");
  entry_keep_a: assert property ( // RQ4
    entry_reset && !lvd_reset && !wr
      |=> $stable(s_q.wake_en) && $stable(s_q.level))
    else $error("entry reset changed wake setup");
  backup_keep_a: assert property ( // RQ12
    !wr && !backup_clr |=> $stable(s_q.backup))
    else $error("backup changed");
  irq_level_a: assert property (
    |(s_q.irq_stat & s_q.irq_mask) |-> ##[0:1] irq)
    else $error("irq not raised");

  // ------------------------------------------------------------------
  // Mode walk, retention and reset checks
  // ------------------------------------------------------------------
  // Each output is registered from the state of the cycle before, so
  // most checks below look one cycle after their cause.
  sequence standby_source_seen;
    s_q.mode == ST_STANDBY && any_wake && !lvd_reset;
  endsequence

  sequence wake_then_run;
    s_q.mode == ST_WAKE ##1 s_q.mode == ST_RUN;
  endsequence

  sequence level_pin_active;
    s_q.mode == ST_STANDBY && pin_hit != 5'h0 && !lvd_reset;
  endsequence

  sequence run_enter_seen;
    s_q.mode == ST_RUN && standby_enter && !lvd_reset;
  endsequence

  standby_entry_a: assert property (
    run_enter_seen |=> s_q.mode == ST_STANDBY)
    else $error("standby not entered");
  wake_walk_a: assert property ( // RQ7
    standby_source_seen |=> wake_then_run)
    else $error("wake did not return to run");
  wake_pulse_a: assert property (
    wake_req |=> !wake_req)
    else $error("wake request longer than a cycle");
  level_wake_a: assert property ( // RQ5
    level_pin_active |=> wake_req && s_q.cause[PINS_MSB:PINS_LSB] != 5'h0)
    else $error("level pin wake missed");
  enable_gate_a: assert property ( // RQ15
    (pin_hit & ~s_q.wake_en[PINS_MSB:PINS_LSB]) == 5'h0)
    else $error("disabled pin counted as wake");
  pin_zero_cause_a: assert property ( // RQ6
    in_standby_pin0_low ##0 !lvd_reset |=> s_q.cause[CAUSE_PIN])
    else $error("pin zero cause missing");
  rtc_off_a: assert property ( // RQ1
    s_q.mode == ST_STANDBY && !s_q.wake_en[RTC_BIT] && !s_q.cause[RTC_BIT]
      |=> !s_q.cause[RTC_BIT])
    else $error("disabled rtc recorded as cause");
  lvd_off_a: assert property ( // RQ2
    s_q.mode == ST_STANDBY && !s_q.wake_en[LVD_BIT] && !s_q.cause[LVD_BIT]
      |=> !s_q.cause[LVD_BIT])
    else $error("disabled lvd recorded as cause");
  cause_run_a: assert property ( // RQ16
    s_q.mode != ST_STANDBY |=> (s_q.cause & ~$past(s_q.cause)) == 8'h0)
    else $error("cause set outside standby");
  cause_read_a: assert property ( // RQ16
    rd && addr == IDX_CAUSE |=> rdata == {24'h0, $past(s_q.cause)})
    else $error("cause read value wrong");
  rdata_idle_a: assert property (
    !rd |=> rdata == 32'h0)
    else $error("read data without read");
  wake_en_rsvd_a: assert property (
    (s_q.wake_en & ~WAKE_EN_MASK) == 8'h0)
    else $error("reserved wake enable bit set");
  lvd_clear_a: assert property (
    lvd_reset |=> s_q.wake_en == 8'h0 && s_q.level == 5'h0)
    else $error("lvd reset kept wake setup");
  retain_reset_a: assert property ( // RQ11
    lvd_reset |=> s_q.retain == RET_NONE)
    else $error("retention kept over lvd reset");
  retain_hold_a: assert property ( // RQ11
    !lvd_reset && !(wr && addr == IDX_RETAIN) |=> $stable(s_q.retain))
    else $error("retention changed without write");
  retain_read_a: assert property ( // RQ8
    rd && addr == IDX_RETAIN |=> rdata[31:2] == 30'h0)
    else $error("retention upper bits not zero");
  retain_none_a: assert property ( // RQ9
    $past(s_q.retain) == RET_NONE |-> bank_keep == 2'h0)
    else $error("retain none not applied");
  bank_one_a: assert property ( // RQ10
    $past(s_q.retain) == RET_BANK1
      |-> bank_keep == (DUAL_BANK ? 2'h2 : 2'h0))
    else $error("bank one code not applied");
  bank_zero_a: assert property ( // RQ10
    $past(s_q.retain) == RET_BANK0
      |-> bank_keep == (DUAL_BANK ? 2'h1 : 2'h0))
    else $error("bank zero code not applied");
  backup_clear_a: assert property ( // RQ13
    backup_clr |=> s_q.backup == 128'h0)
    else $error("backup not cleared");
  backup_hold_a: assert property ( // RQ13
    lvd_reset && !backup_clr && !wr |=> $stable(s_q.backup))
    else $error("backup lost while held");
  entry_mask_a: assert property (
    entry_reset |=> s_q.irq_mask == 2'h0)
    else $error("entry reset kept irq mask");

endmodule : deep_standby_wake_retention

/* verilog/dsw_pkg.sv */
// Package for the deep standby wake and retention block.
package dsw_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_WAKE_EN    = 6'h00;
  localparam logic [5:0] IDX_LEVEL      = 6'h01;
  localparam logic [5:0] IDX_RETAIN     = 6'h02;
  localparam logic [5:0] IDX_CAUSE      = 6'h03;
  localparam logic [5:0] IDX_CTRL       = 6'h04;
  localparam logic [5:0] IDX_IRQ_STAT   = 6'h05;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h06;
  localparam logic [5:0] IDX_BACKUP0    = 6'h08;
  localparam logic [5:0] IDX_BACKUP3    = 6'h0B;
  localparam logic [3:0] HOLD_CLEAR_VAL = 4'h1;

  // ------------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------------
  localparam int RTC_BIT   = 0;
  localparam int LVD_BIT   = 1;
  localparam int PINS_LSB  = 3;
  localparam int PINS_MSB  = 7;
  localparam int NPINS     = 5;
  localparam int CAUSE_PIN = 2;

  localparam logic [1:0] RET_NONE  = 2'h0;
  localparam logic [1:0] RET_BANK1 = 2'h1;
  localparam logic [1:0] RET_BANK0 = 2'h2;
  localparam logic [1:0] RET_BOTH  = 2'h3;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_STANDBY = 2'b01,
    ST_WAKE    = 2'b10
  } mode_e;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    mode_e        mode;
    logic [7:0]   wake_en;
    logic [4:0]   level;
    logic [1:0]   retain;
    logic [7:0]   cause;
    logic [1:0]   irq_stat;
    logic [1:0]   irq_mask;
    logic [127:0] backup;
    logic [31:0]  rdata;
    logic         irq;
    logic         wake;
    logic [1:0]   bank_keep;
  } state_s;

  // Whole-word write of a word into a slot of the backup store.
  function automatic logic [127:0] put_word(input logic [127:0] store,
                                            input logic [1:0]   slot,
                                            input logic [31:0]  word);
    logic [127:0] r;
    r = store;
    r[slot*32 +: 32] = word;
    return r;
  endfunction : put_word

endpackage : dsw_pkg
